// *** fsd_datapath.sv ***
// fsd_datapath: float add/subtract/multiply with special operands, plus
// 60-bit and 18-bit one's-complement add; one request per cycle.
// assumes operands come from issue logic on clk; result one cycle later
`timescale 1ns/10ps
module fsd_datapath
	import fsd_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        op_valid,
	input  wire fsd_op_e     op_code,
	input  wire logic        op_round,
	input  wire logic        op_double,
	input  wire logic [59:0] opnd_j,
	input  wire logic [59:0] opnd_k,
	output logic             result_valid,
	output logic [59:0]      result,
	output logic             result_ind,
	output logic             result_ovf,
	output logic             result_unf
);

	////////////////////////////////////////////////////////////////////
	// helpers

	// complete overflow word carrying the result's sign
	function automatic logic [59:0] fsd_ovf(input logic sgn);
		return sgn ? ~OVF_WORD : OVF_WORD;
	endfunction

	// range check and pack of an ordinary result
	function automatic logic [59:0] fsd_pack(input logic sgn,
	                                         input logic signed [13:0] ex,
	                                         input logic [47:0] mg);
		logic [13:0] pe;
		logic [59:0] wd;
		pe = 14'h0;
		// RULE_20 complete overflow keeps the sign
		if (ex > EXP_MAX) begin
			wd = fsd_ovf(sgn);
		// RULE_02 complete underflow is all zeros
		end else if (ex < EXP_MIN) begin
			wd = UNF_WORD;
		end else begin
			// RULE_01 exponent -1777 packs as 0000/7777
			if (ex >= 14'sh0000) begin
				pe = ex + BIAS_POS;
			end else begin
				pe = ex + BIAS_NEG;
			end
			wd = {1'b0, pe[10:0], mg};
			if (sgn) begin
				wd = ~wd;
			end
		end
		return wd;
	endfunction

	// coefficient placed in upper half of the 98-bit signed accumulator
	function automatic logic signed [97:0] fsd_place(input logic sgn,
	                                                 input logic [47:0] mg,
	                                                 input logic rnd);
		logic signed [97:0] v;
		v = $signed({2'b00, mg, rnd, 47'h0});
		return sgn ? -v : v;
	endfunction

	// 18-bit one's-complement add with end-around carry
	function automatic logic [17:0] fsd_oc_add18(input logic [17:0] a,
	                                             input logic [17:0] b);
		logic [18:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[17:0] + {17'h0, s[18]};
	endfunction

	////////////////////////////////////////////////////////////////////
	// operand classification

	fsd_word_if wj ();
	fsd_word_if wk ();

	assign wj.word = opnd_j;
	assign wk.word = opnd_k;

	fsd_word_class u_cls_j (
		.w (wj.cls)
	);
	fsd_word_class u_cls_k (
		.w (wk.cls)
	);

	////////////////////////////////////////////////////////////////////
	// floating add / subtract

	logic               is_sub;
	logic               k_sign;
	logic               j_big;
	logic signed [13:0] ex_l;
	logic signed [13:0] ex_s;
	logic [13:0]        diff;
	logic [6:0]         shamt;
	logic               rnd_a;
	logic signed [97:0] acc_big;
	logic signed [97:0] acc_small;
	logic signed [97:0] acc_sum;
	logic [97:0]        acc_mag;
	logic signed [13:0] add_ex;
	logic [47:0]        add_coef;
	logic [59:0]        add_word;
	logic [59:0]        k_eff;
	logic [59:0]        add_spec;
	logic               add_is_spec;

	assign is_sub = (op_code == OP_FSUB);
	assign k_sign = is_sub ? ~wk.sign : wk.sign;
	assign k_eff  = is_sub ? ~opnd_k : opnd_k;
	// RULE_08 rounding enters as a half bit on operands
	assign rnd_a  = op_round & ~op_double;

	always_comb begin
		j_big = (wj.expo >= wk.expo);
		ex_l  = j_big ? wj.expo : wk.expo;
		ex_s  = j_big ? wk.expo : wj.expo;
		diff  = ex_l - ex_s;
		// beyond 96 places the smaller coefficient is gone
		shamt = (diff > {7'h0, SHIFT_CAP}) ? SHIFT_CAP : diff[6:0];
		// RULE_09 smaller-exponent coefficient aligned right
		if (j_big) begin
			acc_big   = fsd_place(wj.sign, wj.mag, rnd_a);
			acc_small = fsd_place(k_sign, wk.mag, rnd_a);
		end else begin
			acc_big   = fsd_place(k_sign, wk.mag, rnd_a);
			acc_small = fsd_place(wj.sign, wj.mag, rnd_a);
		end
		acc_sum = acc_big + (acc_small >>> shamt);
		acc_mag = acc_sum[97] ? 98'(-acc_sum) : 98'(acc_sum);
		add_ex  = ex_l;
		// carry past bit 95 moves the point one place
		if (acc_mag[96]) begin
			acc_mag = acc_mag >> 1;
			add_ex  = add_ex + 14'sh0001;
		end
		if (op_double) begin
			// RULE_11 lower half, exponent less 60 octal
			add_coef = acc_mag[47:0];
			add_ex   = add_ex - HALF_SHFT;
		end else begin
			// RULE_10 upper half, larger exponent
			add_coef = acc_mag[95:48];
		end
		// RULE_21 range checks after ordinary arithmetic
		add_word = fsd_pack(acc_sum[97], add_ex, add_coef);
	end

	always_comb begin
		add_is_spec = 1'b1;
		add_spec    = IND_WORD;
		// RULE_04 indefinite operand dominates
		if (wj.is_ind | wk.is_ind) begin
			add_spec = IND_WORD;
		// RULE_17 like infinities survive, opposite ones are indefinite
		// RULE_18 subtrahend infinity flips sign via k_eff
		end else if (wj.is_inf & wk.is_inf) begin
			add_spec = (wj.sign == k_sign) ? opnd_j : IND_WORD;
		end else if (wj.is_inf) begin
			add_spec = opnd_j;
		end else if (wk.is_inf) begin
			add_spec = k_eff;
		end else begin
			add_is_spec = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// floating multiply

	logic [95:0]        prod;
	logic signed [13:0] mul_ex;
	logic [47:0]        mul_coef;
	logic               mul_sign;
	logic [59:0]        mul_word;
	logic [59:0]        mul_spec;
	logic               mul_is_spec;

	always_comb begin
		// RULE_12 96-bit product of the coefficients
		prod     = 96'(wj.mag) * 96'(wk.mag);
		mul_sign = wj.sign ^ wk.sign;
		mul_ex   = wj.expo + wk.expo;
		if (op_double) begin
			// RULE_13 lower half, plain exponent sum
			mul_coef = prod[47:0];
		end else begin
			// RULE_08 round folded in at the same step
			if (op_round) begin
				prod = prod + 96'h0000_0000_0000_8000_0000_0000;
			end
			mul_ex = mul_ex + HALF_SHFT;
			// RULE_07 one-place normalize of normalized products
			if (!prod[95] && prod[94] && wj.is_norm && wk.is_norm) begin
				prod   = prod << 1;
				mul_ex = mul_ex - 14'sh0001;
			end
			mul_coef = prod[95:48];
		end
		// RULE_21 range checks after ordinary arithmetic
		mul_word = fsd_pack(mul_sign, mul_ex, mul_coef);
	end

	always_comb begin
		mul_is_spec = 1'b1;
		mul_spec    = IND_WORD;
		// RULE_04 indefinite operand dominates
		if (wj.is_ind | wk.is_ind) begin
			mul_spec = IND_WORD;
		// RULE_03 infinity times underflow is unresolvable
		end else if ((wj.is_inf & wk.is_unf) | (wk.is_inf & wj.is_unf)) begin
			mul_spec = IND_WORD;
		end else if (wj.is_inf | wk.is_inf) begin
			mul_spec = fsd_ovf(mul_sign);
		end else if (wj.is_unf | wk.is_unf) begin
			mul_spec = UNF_WORD;
		end else begin
			mul_is_spec = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// fixed-point add / subtract

	logic [59:0] long_word;
	logic [17:0] inc_b;
	logic [17:0] inc_r;

	// RULE_14 60-bit one's-complement, carry wraps around
	assign long_word = fsd_oc_add60(opnd_j,
		(op_code == OP_LSUB) ? ~opnd_k : opnd_k);

	// RULE_15 18-bit one's-complement, overflow dropped
	assign inc_b = (op_code == OP_ISUB) ? ~opnd_k[17:0] : opnd_k[17:0];
	assign inc_r = fsd_oc_add18(opnd_j[17:0], inc_b);

	////////////////////////////////////////////////////////////////////
	// result selection and registers

	logic        next_valid;
	logic [59:0] next_result;
	logic        next_ind;
	logic        next_ovf;
	logic        next_unf;
	logic        is_float;
	logic [10:0] res_ef;

	always_comb begin
		next_valid = op_valid;
		is_float   = 1'b1;
		unique case (op_code)
			OP_FADD,
			OP_FSUB: begin
				next_result = add_is_spec ? add_spec : add_word;
			end
			OP_FMUL: begin
				next_result = mul_is_spec ? mul_spec : mul_word;
			end
			OP_LADD,
			OP_LSUB: begin
				next_result = long_word;
				is_float    = 1'b0;
			end
			OP_IADD,
			OP_ISUB: begin
				next_result = {{42{inc_r[17]}}, inc_r};
				is_float    = 1'b0;
			end
			default: begin
				next_result = IND_WORD;
			end
		endcase
		// idle cycles keep the last word on the bus
		if (!op_valid) begin
			next_result = result;
		end
		res_ef = next_result[EXP_HI:EXP_LO] ^ {11{next_result[SIGN_POS]}};
		next_ind = op_valid & is_float & (res_ef == PK_NEGZ);
		next_ovf = op_valid & is_float & (res_ef == PK_MAX);
		next_unf = op_valid & is_float & (next_result == UNF_WORD);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			result_valid <= 1'b0;
			result       <= RST_WORD;
			result_ind   <= 1'b0;
			result_ovf   <= 1'b0;
			result_unf   <= 1'b0;
		end else begin
			result_valid <= next_valid;
			result       <= next_result;
			result_ind   <= next_ind;
			result_ovf   <= next_ovf;
			result_unf   <= next_unf;
		end
	end

endmodule

// *** fsd_datapath_properties.sv ***
// fsd_datapath_properties: port checker for the float datapath
// assumes one clock domain, reset asynchronous and active high
`timescale 1ns/10ps
module fsd_datapath_chk
	import fsd_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        op_valid,
	input wire fsd_op_e     op_code,
	input wire logic        op_round,
	input wire logic        op_double,
	input wire logic [59:0] opnd_j,
	input wire logic [59:0] opnd_k,
	input wire logic        result_valid,
	input wire logic [59:0] result,
	input wire logic        result_ind,
	input wire logic        result_ovf,
	input wire logic        result_unf
);
	logic fl_op;
	logic fx_op;
	logic j_indef;
	logic k_indef;
	logic j_ord;
	assign fl_op   = op_valid && op_code inside {OP_FADD, OP_FSUB, OP_FMUL};
	assign fx_op   = op_valid &&
		op_code inside {OP_LADD, OP_LSUB, OP_IADD, OP_ISUB};
	assign j_indef = opnd_j[59:48] inside {12'h3FF, 12'hC00};
	assign k_indef = opnd_k[59:48] inside {12'h3FF, 12'hC00};
	assign j_ord   = !(opnd_j[59:48] inside {12'h3FF, 12'hC00, 12'h7FF,
		12'h800});

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////
	lat_round_a: assert property (op_valid && op_round |=> result_valid)
		else $error("rounded request gave no result a cycle later");
	indef_in_a: assert property (fl_op && (j_indef || k_indef) |=>
		result == IND_WORD && result_ind)
		else $error("indefinite operand did not give indefinite result");
	indef_pos_a: assert property (result_valid && result_ind |->
		result == IND_WORD)
		else $error("indefinite result not in positive form");
	norm_mul_a: assert property (fl_op && op_code == OP_FMUL &&
		!op_double && opnd_j[59] != opnd_j[47] && opnd_k[59] != opnd_k[47]
		|=> result_ovf || result_unf || result_ind || result[59] != result[47])
		else $error("product of normalized operands not normalized");
	unf_zero_a: assert property (result_valid && result_unf |->
		result == UNF_WORD)
		else $error("underflow result is not the zero word");
	ovf_mul_a: assert property (fl_op && op_code == OP_FMUL ##1
		result_ovf |-> (result ^ {60{result[59]}}) == OVF_WORD)
		else $error("product overflow word has nonzero coefficient");
	fix_flag_a: assert property (fx_op |=>
		!(result_ind || result_ovf || result_unf))
		else $error("fixed-point operation raised a float flag");
	inc_sext_a: assert property (op_valid &&
		op_code inside {OP_IADD, OP_ISUB} |=> result[59:18] == {42{result[17]}})
		else $error("short result not sign-extended");
	add_over_a: assert property (fl_op && op_code == OP_FADD && j_ord &&
		opnd_k == OVF_WORD |=> result == OVF_WORD)
		else $error("sum with positive overflow operand wrong");

	cover property (result_valid && result_ind);
	cover property (result_valid && result_ovf);
	cover property (op_valid && op_double ##1 result_valid);
endmodule

bind fsd_datapath fsd_datapath_chk i_fsd_datapath_chk (.clk, .rst,
	.op_valid, .op_code, .op_round, .op_double, .opnd_j, .opnd_k,
	.result_valid, .result, .result_ind, .result_ovf, .result_unf);

// *** fsd_issue_model.sv ***
// fsd_issue_model: stands in for instruction issue and operand registers
// assumes callers sit at a rising clock edge when they call a task
`timescale 1ns/10ps
module fsd_issue_model
	import fsd_pkg::*;
(
	output logic        op_valid,
	output fsd_op_e     op_code,
	output logic        op_round,
	output logic        op_double,
	output logic [59:0] opnd_j,
	output logic [59:0] opnd_k
);
	initial begin
		op_valid = 1'b0;
		op_code = OP_FADD;
		op_round = 1'b0;
		op_double = 1'b0;
		opnd_j = 60'h0;
		opnd_k = 60'h0;
	end

	task automatic issue(input fsd_op_e op, input logic rnd, input logic dbl,
		input logic [59:0] j, input logic [59:0] k);
		op_valid  <= 1'b1;
		op_code   <= op;
		op_round  <= rnd;
		op_double <= dbl;
		opnd_j    <= j;
		opnd_k    <= k;
	endtask

	// released operands show the inverse, never the stale word
	task automatic idle();
		op_valid <= 1'b0;
		opnd_j   <= ~opnd_j;
		opnd_k   <= ~opnd_k;
	endtask
endmodule

// *** fsd_pkg.sv ***
// fsd_pkg: constants, opcode enum and shared arithmetic for the float
// special-operand datapath; assumes a 60-bit one's-complement word format.
// Functional notes
// RULE_01: packed exponent 0000/7777 is smallest exponent; such results stay partial underflow.
// RULE_02: exponent below -1777 octal returns the all-zero complete underflow word.
// RULE_03: unresolvable calculation returns indefinite: exponent 1777 packed, zero coefficient.
// RULE_04: any indefinite operand forces an indefinite result.
// RULE_05: indefinite is produced positive, recognized with either sign.
// RULE_06: word is normalized when bit 59 differs from bit 47.
// RULE_07: multiply normalizes results from normalized operands; add may not.
// RULE_08: rounding alters operands beforehand, costing no extra cycles.
// RULE_09: add aligns smaller-exponent coefficient in upper half, shifts right by difference.
// RULE_10: single add returns upper 48 sum bits with larger exponent.
// RULE_11: double add returns lower 48 sum bits, larger exponent minus 60 octal.
// RULE_12: single multiply returns upper 48 product bits, exponent sum plus 60 octal.
// RULE_13: double multiply returns lower 48 product bits, plain exponent sum.
// RULE_14: long add/subtract on 60-bit one's-complement, overflow ignored.
// RULE_15: increment add/subtract on 18-bit one's-complement, overflow ignored.
// RULE_16: ordinary words exclude infinities and indefinites; nonzero ones also exclude zeros.
// RULE_17: add returns infinite operand, like infinities, else indefinite for opposite infinities.
// RULE_18: subtract returns infinite minuend or negated infinite subtrahend, else indefinite.
// RULE_19: sign bit 59, biased exponent bits 58..48, coefficient bits 47..0.
// RULE_20: exponent above +1777 octal returns signed complete overflow with zero coefficient.
// RULE_21: ordinary results are computed first, then range checked.
package fsd_pkg;

	localparam int WORD_W = 60;
	localparam int COEF_W = 48;
	localparam int EXPF_W = 11;
	localparam int INC_W  = 18;

	// field positions
	localparam int SIGN_POS = 59;
	localparam int EXP_HI   = 58;
	localparam int EXP_LO   = 48;
	localparam int NORM_POS = 47;

	// packed exponent codes, positive coefficient form
	localparam logic [10:0] PK_MAX  = 11'h7FF;
	localparam logic [10:0] PK_NEGZ = 11'h3FF;
	localparam logic [10:0] PK_MIN  = 11'h000;

	// unbiased exponent limits and offsets, 14-bit signed; 7-bit alignment shift cap
	localparam logic signed [13:0] EXP_MAX   = 14'sh03FF;
	localparam logic signed [13:0] EXP_MIN   = 14'sh3C01;
	localparam logic signed [13:0] BIAS_POS  = 14'sh0400;
	localparam logic signed [13:0] BIAS_NEG  = 14'sh03FF;
	localparam logic signed [13:0] HALF_SHFT = 14'sh0030;
	localparam logic [6:0]         SHIFT_CAP = 7'h60;

	// special words
	localparam logic [59:0] IND_WORD = 60'h3FF_0000_0000_0000;
	localparam logic [59:0] UNF_WORD = 60'h000_0000_0000_0000;
	localparam logic [59:0] OVF_WORD = 60'h7FF_0000_0000_0000;
	localparam logic [59:0] RST_WORD = 60'h000_0000_0000_0000;

	typedef enum logic [2:0] {
		OP_FADD = 3'h0,
		OP_FSUB = 3'h1,
		OP_FMUL = 3'h3,
		OP_LADD = 3'h2,
		OP_LSUB = 3'h6,
		OP_IADD = 3'h7,
		OP_ISUB = 3'h5
	} fsd_op_e;

	// one's-complement add with end-around carry
	function automatic logic [59:0] fsd_oc_add60(input logic [59:0] a,
	                                             input logic [59:0] b);
		logic [60:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[59:0] + {59'h0, s[60]};
	endfunction

endpackage

// *** fsd_word_class.sv ***
// fsd_word_class: unpacks and classifies one 60-bit floating word
// assumes the word is stable during the cycle; purely combinational
`timescale 1ns/10ps
module fsd_word_class
	import fsd_pkg::*;
(
	fsd_word_if.cls w
);
	logic [59:0] tru;
	logic [10:0] ef;

	// RULE_19 field layout
	always_comb begin
		tru = w.word[SIGN_POS] ? ~w.word : w.word;
		ef  = tru[EXP_HI:EXP_LO];
		w.sign = w.word[SIGN_POS];
		w.mag  = tru[COEF_W-1:0];
		if (ef[10]) begin
			w.expo = $signed({3'b000, ef}) - BIAS_POS;
		end else begin
			w.expo = $signed({3'b000, ef}) - BIAS_NEG;
		end
	end

	// RULE_05 sign-independent indefinite test
	assign w.is_ind  = (ef == PK_NEGZ);
	// RULE_16 special classes
	assign w.is_inf  = (ef == PK_MAX);
	// RULE_01 smallest exponent marks underflow
	assign w.is_unf  = (ef == PK_MIN);
	// RULE_06 normalized test
	assign w.is_norm = w.word[SIGN_POS] ^ w.word[NORM_POS];
endmodule

// *** fsd_word_if.sv ***
// fsd_word_if: one operand word and its unpacked fields and class
// assumes a classifier drives the fields from the word in the same cycle
`timescale 1ns/10ps
interface fsd_word_if;
	logic [59:0]        word;
	logic               sign;
	logic signed [13:0] expo;
	logic [47:0]        mag;
	logic               is_inf;
	logic               is_ind;
	logic               is_unf;
	logic               is_norm;

	modport cls (
		input  word,
		output sign,
		output expo,
		output mag,
		output is_inf,
		output is_ind,
		output is_unf,
		output is_norm
	);
	modport use_side (
		input word,
		input sign,
		input expo,
		input mag,
		input is_inf,
		input is_ind,
		input is_unf,
		input is_norm
	);
endinterface

// *** tb_float_special_operand_datapath.sv ***
// tb_float_special_operand_datapath: self-checking bench for fsd_datapath
// assumes the issue model drives requests and the checker is bound
`timescale 1ns/10ps
module tb_float_special_operand_datapath
	import fsd_pkg::*;
;
	localparam logic [59:0] W1   = 60'h400_0000_0000_0001;
	localparam logic [59:0] NINF = 60'h800_FFFF_FFFF_FFFF;
	localparam logic [59:0] NIDF = 60'hC00_FFFF_FFFF_FFFF;
	localparam logic [59:0] NM   = 60'h400_8000_0000_0000;
	localparam logic [59:0] BIG  = 60'h7FE_0000_0000_0001;
	localparam logic [59:0] SML  = 60'h1A7_0000_0000_0001;
	logic        clk;
	logic        rst;
	logic        op_valid;
	fsd_op_e     op_code;
	logic        op_round;
	logic        op_double;
	logic [59:0] opnd_j;
	logic [59:0] opnd_k;
	logic        result_valid;
	logic [59:0] result;
	logic        result_ind;
	logic        result_ovf;
	logic        result_unf;
	int          err_total = 0;
	int          tests_run = 0;

	fsd_issue_model i_fsd_issue_model (.op_valid, .op_code, .op_round,
		.op_double, .opnd_j, .opnd_k);
	fsd_datapath i_fsd_datapath (.clk, .rst, .op_valid, .op_code, .op_round,
		.op_double, .opnd_j, .opnd_k, .result_valid, .result, .result_ind,
		.result_ovf, .result_unf);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////
	task automatic cmp(input string nm, input logic [59:0] e,
		input logic [59:0] g);
		tests_run++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask

	task automatic chk(input logic [59:0] e, input logic fl);
		cmp("result", e, result);
		cmp("valid", 60'h1, {59'h0, result_valid});
		cmp("indef flag", {59'h0, fl && e === IND_WORD}, {59'h0, result_ind});
		cmp("ovf flag", {59'h0, fl && e[59:48] inside {12'h7FF, 12'h800}},
			{59'h0, result_ovf});
		cmp("unf flag", {59'h0, fl && e === UNF_WORD}, {59'h0, result_unf});
	endtask

	task automatic go(input fsd_op_e op, input logic rnd, input logic dbl,
		input logic [59:0] j, input logic [59:0] k, input logic [59:0] e);
		i_fsd_issue_model.issue(op, rnd, dbl, j, k);
		@(posedge clk);
		i_fsd_issue_model.idle();
		#1;
		chk(e, op inside {OP_FADD, OP_FSUB, OP_FMUL});
		@(posedge clk);
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic t_add();
		go(OP_FADD, 1'b0, 1'b0, 60'h401_0000_0000_0001, W1, 60'h401_0000_0000_0001);
		go(OP_FADD, 1'b0, 1'b1, 60'h401_0000_0000_0001, W1, 60'h3D0_8000_0000_0000);
		go(OP_FADD, 1'b1, 1'b0, W1, W1, 60'h400_0000_0000_0003);
		go(OP_FADD, 1'b0, 1'b1, W1, 60'h402_0000_0000_0001, 60'h3D1_4000_0000_0000);
		go(OP_FSUB, 1'b0, 1'b1, 60'h401_0000_0000_0001, W1, 60'h3D0_8000_0000_0000);
		go(OP_FADD, 1'b0, 1'b0, ~W1, ~W1, 60'hBFF_FFFF_FFFF_FFFD);
		$display("add alignment done");
	endtask

	task automatic t_mul();
		go(OP_FMUL, 1'b0, 1'b0, W1, W1, 60'h430_0000_0000_0000);
		go(OP_FMUL, 1'b0, 1'b1, W1, W1, W1);
		go(OP_FMUL, 1'b0, 1'b0, NM, NM, 60'h42F_8000_0000_0000);
		go(OP_FMUL, 1'b1, 1'b0, NM, NM, 60'h42F_8000_0000_0001);
		go(OP_FMUL, 1'b0, 1'b0, ~NM, NM, 60'hBD0_7FFF_FFFF_FFFF);
		$display("multiply halves done");
	endtask

	task automatic t_special();
		go(OP_FADD, 1'b0, 1'b0, W1, OVF_WORD, OVF_WORD);
		go(OP_FADD, 1'b0, 1'b0, W1, NINF, NINF);
		go(OP_FADD, 1'b0, 1'b0, NINF, NINF, NINF);
		go(OP_FADD, 1'b0, 1'b0, OVF_WORD, NINF, IND_WORD);
		go(OP_FADD, 1'b0, 1'b0, NIDF, W1, IND_WORD);
		go(OP_FADD, 1'b0, 1'b0, W1, IND_WORD, IND_WORD);
		go(OP_FSUB, 1'b0, 1'b0, W1, OVF_WORD, NINF);
		go(OP_FSUB, 1'b0, 1'b0, OVF_WORD, W1, OVF_WORD);
		go(OP_FSUB, 1'b0, 1'b0, OVF_WORD, OVF_WORD, IND_WORD);
		go(OP_FSUB, 1'b0, 1'b0, NINF, OVF_WORD, NINF);
		go(OP_FMUL, 1'b0, 1'b0, OVF_WORD, UNF_WORD, IND_WORD);
		go(OP_FMUL, 1'b0, 1'b0, NIDF, W1, IND_WORD);
		go(OP_FADD, 1'b0, 1'b0, UNF_WORD, NINF, NINF);
		$display("special operands done");
	endtask

	task automatic t_range();
		go(OP_FMUL, 1'b0, 1'b0, BIG, BIG, OVF_WORD);
		go(OP_FMUL, 1'b0, 1'b0, ~BIG, BIG, NINF);
		go(OP_FMUL, 1'b0, 1'b0, SML, SML, UNF_WORD);
		go(OP_FMUL, 1'b0, 1'b1, SML, 60'h258_0000_0000_0001, 60'h1);
		go(OP_FADD, 1'b0, 1'b1, 60'h010_0000_0000_0001, 60'h010_0000_0000_0001, UNF_WORD);
		$display("exponent range done");
	endtask

	task automatic t_fixed();
		go(OP_LADD, 1'b0, 1'b0, 60'hFFF_FFFF_FFFF_FFFE, 60'h2, 60'h1);
		go(OP_LADD, 1'b0, 1'b0, 60'h7FF_FFFF_FFFF_FFFF, 60'h1, 60'h800_0000_0000_0000);
		go(OP_LSUB, 1'b0, 1'b0, 60'h5, 60'h7, 60'hFFF_FFFF_FFFF_FFFD);
		go(OP_IADD, 1'b0, 1'b0, 60'hABC_0000_0003_FFFE, 60'h2, 60'h1);
		go(OP_IADD, 1'b0, 1'b0, 60'h1_FFFF, 60'h1, 60'hFFF_FFFF_FFFE_0000);
		go(OP_ISUB, 1'b0, 1'b0, 60'h5, 60'h7, 60'hFFF_FFFF_FFFF_FFFD);
		$display("fixed point done");
	endtask

	task automatic t_b2b();
		i_fsd_issue_model.issue(OP_LADD, 1'b0, 1'b0, 60'h5, 60'h7);
		@(posedge clk);
		i_fsd_issue_model.issue(OP_FADD, 1'b0, 1'b0, W1, W1);
		#1;
		chk(60'hC, 1'b0);
		@(posedge clk);
		i_fsd_issue_model.idle();
		#1;
		chk(60'h400_0000_0000_0002, 1'b1);
		@(posedge clk);
		#1;
		cmp("idle valid", 60'h0, {59'h0, result_valid});
		cmp("held result", 60'h400_0000_0000_0002, result);
		$display("back to back done");
	endtask

	initial begin
		#100000;
		err_total++;
		report_and_stop();
	end

	initial begin
		rst = 1'b1;
		repeat (12) @(posedge clk);
		#1;
		cmp("reset valid", 60'h0, {59'h0, result_valid});
		cmp("reset result", 60'h0, result);
		@(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_add();
		t_mul();
		t_special();
		t_range();
		t_fixed();
		t_b2b();
		report_and_stop();
	end
endmodule
